// ---- rdt_edge_sync.sv ----
`timescale 1ns/1ps

module rdt_edge_sync
	import rdt_pkg::*;
(
	input wire logic clock, // Peripheral clock
	input wire logic rstn, // Synchronised active-low reset
	input wire logic asyncIn, // Pin level from outside
	output logic risePulse // One-cycle pulse per rising edge
);

	rdt_sync_t s_r;
	rdt_sync_t s_nxt;

	// ----------------------------------------------------------------
	// Two-flop synchroniser and edge detector
	// ----------------------------------------------------------------
	// Only the second and third stages feed the edge compare, so a metastable
	// first stage never reaches logic
	always_comb begin
		s_nxt = s_r;
		s_nxt.meta = asyncIn;
		s_nxt.sync = s_r.meta;
		s_nxt.prev = s_r.sync;
		s_nxt.rise = s_r.sync & ~s_r.prev;
	end

	// State register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign risePulse = s_r.rise;

endmodule

// ---- rdt_pin_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// External pin driver: start edge or slow clock
// ----------------------------------------------------------------
module rdt_pin_model (
	input wire logic clock, // Peripheral clock
	input wire logic rstn, // Active-low reset
	input wire logic start, // Begin a burst
	input wire logic [7:0] pulses, // Rising edges to send
	input wire logic [3:0] halfPer, // Cycles per level
	output logic pin, // Pin level, rests low
	output logic busy // Burst in progress
);
	int rem;
	int cnt;

	// Levels last two cycles or more, or the two-flop sampler could miss an edge
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pin <= 1'b0;
			busy <= 1'b0;
			rem = 0;
			cnt = 0;
		end else if (start) begin
			rem = 2 * pulses;
			cnt = 0;
			busy <= 1'b1;
		end else if (rem > 0) begin
			cnt++;
			if (cnt >= ((halfPer < 4'h2) ? 2 : halfPer)) begin
				cnt = 0;
				pin <= ~pin;
				rem--;
				busy <= (rem > 0);
			end
		end
	end
endmodule

// ---- rdt_pkg.sv ----
`include "rdt_timer_map.svh"

package rdt_pkg;

	// Control bits, bit 0 at the bottom
	typedef struct packed {
		logic intEn;
		logic extClockSelect;
		logic extEnableSelect;
		logic timerRunBit;
	} rdt_ctrl_t;

	// Whole state of the timer top
	typedef struct packed {
		rdt_ctrl_t ctrl;
		logic [`RDT_CNT_W-1:0] countVal;
		logic [`RDT_CNT_W-1:0] reloadVal;
		logic irqPendingBit;
		logic irqMask;
		logic extArmed;
		logic [`RDT_CNT_W-1:0] prdata;
		logic pready;
		logic pslverr;
		logic irqOut;
	} rdt_state_t;

	// State of the input synchroniser and edge detector
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic rise;
	} rdt_sync_t;

	// Register selected by the bus address
	typedef enum logic [2:0] {
		RDT_SEL_NONE,
		RDT_SEL_CTRL,
		RDT_SEL_VALUE,
		RDT_SEL_RELOAD,
		RDT_SEL_STATUS,
		RDT_SEL_MASK
	} rdt_sel_t;

endpackage

// ---- rdt_timer.sv ----
`timescale 1ns/1ps
`include "rdt_timer_map.svh"

// Overview of operation
// - The timer is one 32-bit down-counter.
// - On a count tick at zero the counter loads the reload value and counts down from there.
// - Reaching zero with interrupt enable set sets the pending bit, which raises the timer interrupt while the mask bit is set.
// - The pending bit stays set until software clears it.
// - A bus write to the count value register replaces the counter at once.
// - When zero is reached with interrupt enable set in the cycle the pending bit is cleared, the bit stays set.
// - With external enable selected, a rising edge on the external pin starts the count.
// - With external clock selected, the pin is synchronised by two flops and each rising edge is one tick.
// - Control holds run at bit 0, external enable at 1, external clock at 2, interrupt enable at 3, reset zero.
// - Writing one to bit 0 of the status register clears the pending bit, a zero leaves it.
// - A read of the count value register returns the live counter.
module rdt_timer
	import rdt_pkg::*;
(
	input wire logic clock, // Peripheral clock, 125 MHz
	input wire logic rstn, // Active-low asynchronous reset
	input wire logic [`RDT_ADDR_W-1:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [`RDT_CNT_W-1:0] pwdata, // APB write data
	output logic [`RDT_CNT_W-1:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic extTimerInput, // External enable or clock pin
	output logic irq // Level interrupt
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rstMeta_r;
	logic rstSync_r;

	// Assert at once, release after two edges
	// Every flop behind this pair leaves reset on the same edge, never on a metastable one
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	// ----------------------------------------------------------------
	// External pin conditioning
	// ----------------------------------------------------------------
	logic extRise;

	// Pin is slow by contract, so one rising-edge pulse per period
	rdt_edge_sync u_extSync (
		.clock(clock),
		.rstn(rstSync_r),
		.asyncIn(extTimerInput),
		.risePulse(extRise)
	);

	// ----------------------------------------------------------------
	// State and decode helpers
	// ----------------------------------------------------------------
	rdt_state_t s_r;
	rdt_state_t s_nxt;
	rdt_sel_t sel;
	logic setupPh;
	logic accessDone;
	logic wrDone;
	logic rdDone;
	logic valueWr;
	logic statusClr;
	logic tick;
	logic zeroHit;
	logic pendSet;

	// Address decode, one aligned word per register
	always_comb begin
		if (paddr == `RDT_OFF_CTRL) begin
			sel = RDT_SEL_CTRL;
		end else if (paddr == `RDT_OFF_VALUE) begin
			sel = RDT_SEL_VALUE;
		end else if (paddr == `RDT_OFF_RELOAD) begin
			sel = RDT_SEL_RELOAD;
		end else if (paddr == `RDT_OFF_STATUS) begin
			sel = RDT_SEL_STATUS;
		end else if (paddr == `RDT_OFF_MASK) begin
			sel = RDT_SEL_MASK;
		end else begin
			sel = RDT_SEL_NONE;
		end
	end

	// Bus phases; writes and read side effects land only at completion
	assign setupPh = psel & ~penable;
	assign accessDone = psel & penable & s_r.pready;
	assign wrDone = accessDone & pwrite;
	assign rdDone = accessDone & ~pwrite;
	assign valueWr = wrDone & (sel == RDT_SEL_VALUE);

	// Count ticks: external clock edges or every cycle, gated by run and arming
	always_comb begin
		tick = s_r.ctrl.timerRunBit & (~s_r.ctrl.extEnableSelect | s_r.extArmed);
		if (s_r.ctrl.extClockSelect) begin
			tick = tick & extRise;
		end
	end

	assign zeroHit = tick & (s_r.countVal == `RDT_RST_COUNT);
	assign pendSet = zeroHit & s_r.ctrl.intEn;

	// Clear by write-one or by read of the status word
	assign statusClr = (wrDone & (sel == RDT_SEL_STATUS) & pwdata[`RDT_STS_PEND_BIT])
		| (rdDone & (sel == RDT_SEL_STATUS));

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;

		// Control, reload and mask register writes
		if (wrDone && sel == RDT_SEL_CTRL) begin
			s_nxt.ctrl.timerRunBit = pwdata[`RDT_CTRL_RUN_BIT];
			s_nxt.ctrl.extEnableSelect = pwdata[`RDT_CTRL_EXTEN_BIT];
			s_nxt.ctrl.extClockSelect = pwdata[`RDT_CTRL_EXTCLK_BIT];
			s_nxt.ctrl.intEn = pwdata[`RDT_CTRL_INTEN_BIT];
		end
		if (wrDone && sel == RDT_SEL_RELOAD) begin
			s_nxt.reloadVal = pwdata;
		end
		if (wrDone && sel == RDT_SEL_MASK) begin
			s_nxt.irqMask = pwdata[`RDT_MASK_PEND_BIT];
		end

		// Arming drops whenever the run or select bit is off, so each start needs a fresh edge
		if (!s_r.ctrl.timerRunBit || !s_r.ctrl.extEnableSelect) begin
			s_nxt.extArmed = 1'b0;
		end else if (extRise) begin
			s_nxt.extArmed = 1'b1;
		end

		// Counter; a software write beats the count in the same cycle
		if (valueWr) begin
			s_nxt.countVal = pwdata;
		end else if (zeroHit) begin
			s_nxt.countVal = s_r.reloadVal;
		end else if (tick) begin
			s_nxt.countVal = s_r.countVal - `RDT_CNT_W'(1);
		end

		// Pending bit, set beats clear
		s_nxt.irqPendingBit = (s_r.irqPendingBit & ~statusClr) | pendSet;

		// Registered interrupt level from the next state
		s_nxt.irqOut = s_nxt.irqPendingBit & s_nxt.irqMask;

		// Bus answer: read data sampled in setup, presented with ready in access
		s_nxt.pready = setupPh;
		s_nxt.pslverr = setupPh & (sel == RDT_SEL_NONE);
		if (setupPh) begin
			if (pwrite) begin
				s_nxt.prdata = `RDT_RST_RDATA;
			end else if (sel == RDT_SEL_CTRL) begin
				s_nxt.prdata = `RDT_CNT_W'(s_r.ctrl);
			end else if (sel == RDT_SEL_VALUE) begin
				s_nxt.prdata = s_r.countVal;
			end else if (sel == RDT_SEL_RELOAD) begin
				s_nxt.prdata = s_r.reloadVal;
			end else if (sel == RDT_SEL_STATUS) begin
				s_nxt.prdata = `RDT_CNT_W'(s_r.irqPendingBit);
			end else if (sel == RDT_SEL_MASK) begin
				s_nxt.prdata = `RDT_CNT_W'(s_r.irqMask);
			end else begin
				s_nxt.prdata = `RDT_RST_RDATA;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rstSync_r) begin
		if (!rstSync_r) begin
			s_r.ctrl <= rdt_ctrl_t'(`RDT_RST_CTRL);
			s_r.countVal <= `RDT_RST_COUNT;
			s_r.reloadVal <= `RDT_RST_RELOAD;
			s_r.irqPendingBit <= `RDT_RST_STATUS;
			s_r.irqMask <= `RDT_RST_MASK;
			s_r.extArmed <= 1'b0;
			s_r.prdata <= `RDT_RST_RDATA;
			s_r.pready <= 1'b0;
			s_r.pslverr <= 1'b0;
			s_r.irqOut <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state flops
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign irq = s_r.irqOut;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstSync_r);

	property p_decrement;
		tick && !zeroHit && !valueWr |=> s_r.countVal == $past(s_r.countVal) - `RDT_CNT_W'(1);
	endproperty
	a_decrement: assert property (p_decrement) else $error("counter did not step down by one");

	property p_hold;
		!tick && !valueWr |=> $stable(s_r.countVal);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved without a tick");

	property p_reload;
		zeroHit && !valueWr |=> s_r.countVal == $past(s_r.reloadVal);
	endproperty
	a_reload: assert property (p_reload) else $error("counter did not reload at zero");

	property p_irq_on_zero;
		zeroHit && s_r.ctrl.intEn && s_r.irqMask && !(wrDone && sel == RDT_SEL_MASK) |=> irq;
	endproperty
	a_irq_on_zero: assert property (p_irq_on_zero) else $error("no interrupt after zero");

	property p_pending_held;
		s_r.irqPendingBit && !statusClr |=> s_r.irqPendingBit;
	endproperty
	a_pending_held: assert property (p_pending_held) else $error("pending bit dropped without clear");

	property p_value_write;
		valueWr |=> s_r.countVal == $past(pwdata);
	endproperty
	a_value_write: assert property (p_value_write) else $error("count write not taken");

	property p_set_wins;
		pendSet && statusClr |=> s_r.irqPendingBit;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear won over a set");

	property p_ext_enable_wait;
		s_r.ctrl.extEnableSelect && !s_r.extArmed && !valueWr |=> $stable(s_r.countVal);
	endproperty
	a_ext_enable_wait: assert property (p_ext_enable_wait) else $error("counted before external start");

	property p_ext_clock;
		s_r.ctrl.extClockSelect && !extRise && !valueWr |=> $stable(s_r.countVal);
	endproperty
	a_ext_clock: assert property (p_ext_clock) else $error("counted without external edge");

	property p_ctrl_read;
		setupPh && !pwrite && sel == RDT_SEL_CTRL |=> pready && prdata == `RDT_CNT_W'($past(s_r.ctrl));
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

	property p_w1c;
		wrDone && sel == RDT_SEL_STATUS && pwdata[`RDT_STS_PEND_BIT] && !pendSet |=> !s_r.irqPendingBit;
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear");

	property p_value_read;
		setupPh && !pwrite && sel == RDT_SEL_VALUE |=> pready && prdata == $past(s_r.countVal);
	endproperty
	a_value_read: assert property (p_value_read) else $error("count read not live");

	property p_irq_follows;
		s_r.irqPendingBit && s_r.irqMask && !statusClr && !(wrDone && sel == RDT_SEL_MASK) |=> irq ##1 1'b1;
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("interrupt dropped while pending");

	property p_ext_arm;
		s_r.ctrl.timerRunBit && s_r.ctrl.extEnableSelect && extRise |=> s_r.extArmed;
	endproperty
	a_ext_arm: assert property (p_ext_arm) else $error("start edge did not arm the counter");

	property p_ctrl_write;
		wrDone && sel == RDT_SEL_CTRL |=> s_r.ctrl == rdt_ctrl_t'($past(pwdata[`RDT_CTRL_W-1:0]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write not taken");

	property p_run_off;
		!s_r.ctrl.timerRunBit && !valueWr |=> $stable(s_r.countVal);
	endproperty
	a_run_off: assert property (p_run_off) else $error("counter moved with run off");

	c_reload: cover property (zeroHit ##1 tick);
	c_ext_clock: cover property (s_r.ctrl.extClockSelect && extRise && tick);
	c_collision: cover property (pendSet && statusClr);
	c_status_read: cover property (rdDone && sel == RDT_SEL_STATUS && s_r.irqPendingBit);
	c_ext_start: cover property (s_r.ctrl.extEnableSelect && extRise && !s_r.extArmed);

endmodule

// ---- rdt_timer_map.svh ----
`ifndef RDT_TIMER_MAP_SVH
`define RDT_TIMER_MAP_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define RDT_CNT_W 32
`define RDT_ADDR_W 12
`define RDT_CTRL_W 4

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RDT_OFF_CTRL 12'h000
`define RDT_OFF_VALUE 12'h004
`define RDT_OFF_RELOAD 12'h008
`define RDT_OFF_STATUS 12'h00c
`define RDT_OFF_MASK 12'h010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RDT_CTRL_RUN_BIT 0
`define RDT_CTRL_EXTEN_BIT 1
`define RDT_CTRL_EXTCLK_BIT 2
`define RDT_CTRL_INTEN_BIT 3
`define RDT_STS_PEND_BIT 0
`define RDT_MASK_PEND_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RDT_RST_CTRL 4'h0
`define RDT_RST_COUNT 32'h0000_0000
`define RDT_RST_RELOAD 32'h0000_0000
`define RDT_RST_STATUS 1'b0
`define RDT_RST_MASK 1'b1
`define RDT_RST_RDATA 32'h0000_0000

`endif

// ---- test_apb_reload_down_timer.sv ----
`timescale 1ns/1ps
`include "rdt_timer_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch at %0t got %h expected %h", $time, (g), (e)); end end

module test_apb_reload_down_timer;
	logic clock, rstn, psel, penable, pwrite, pready, pslverr, irq, extStart, extPin, extBusy, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed, a, b, mReload;
	logic [7:0] extPulses;
	logic [3:0] extHalf;
	int num_errors = 0;
	int checks = 0;

	rdt_timer dut_u (.clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.extTimerInput(extPin), .irq(irq));
	rdt_pin_model pin_u (.clock(clock), .rstn(rstn), .start(extStart), .pulses(extPulses),
		.halfPer(extHalf), .pin(extPin), .busy(extBusy));

	// Free-running 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Reference counter: k ticks, reloading at zero
	function logic [31:0] step(input logic [31:0] x, input int k);
		repeat (k) x = (x == 32'h0) ? mReload : x - 32'h1;
		return x;
	endfunction

	// One APB transfer; the request holds until pready is sampled high
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) num_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task idle(input int n);
		repeat (n) @(posedge clock);
	endtask

	// Sends pin pulses and waits for the burst to end, bounded
	task pins(input logic [7:0] p, input logic [3:0] h);
		int n;
		extPulses <= p;
		extHalf <= h;
		extStart <= 1'b1;
		@(posedge clock);
		extStart <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (extBusy !== 1'b0 && n < 500);
		idle(8);
	endtask

	task test_done;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Hang guard, well past the expected run length
	initial begin
		idle(20000);
		num_errors++;
		test_done;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		{psel, penable, pwrite, extStart} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		extPulses = 8'h0;
		extHalf = 4'h2;
		seed = 32'h57c9;
		idle(4);
		rstn <= 1'b1;
		idle(3);
		apb(0, `RDT_OFF_CTRL, 0); `CHK(rd, 32'h0)
		apb(0, `RDT_OFF_VALUE, 0); `CHK(rd, 32'h0)
		apb(0, `RDT_OFF_RELOAD, 0); `CHK(rd, 32'h0)
		apb(0, `RDT_OFF_MASK, 0); `CHK(rd, 32'h1)
		apb(0, 12'h014, 0); `CHK({err, rd}, 33'h1_0000_0000)
		// Control bits hold, reserved bits read zero; run stays off here
		for (int i = 0; i < 4; i++) begin
			a = rnd() & 32'hffff_fffe;
			apb(1, `RDT_OFF_CTRL, a);
			apb(0, `RDT_OFF_CTRL, 0); `CHK(rd, a & 32'hf)
		end
		apb(1, `RDT_OFF_CTRL, 0);
		for (int i = 0; i < 3; i++) begin
			a = rnd();
			apb(1, `RDT_OFF_VALUE, a);
			apb(0, `RDT_OFF_VALUE, 0); `CHK(rd, a)
		end
		// Periodic run: reads three cycles apart follow the reference counter
		mReload = (rnd() & 32'h7) + 32'h3;
		apb(1, `RDT_OFF_RELOAD, mReload);
		apb(1, `RDT_OFF_VALUE, 32'h4);
		apb(1, `RDT_OFF_CTRL, 32'h9);
		apb(0, `RDT_OFF_VALUE, 0);
		a = rd;
		for (int i = 0; i < 6; i++) begin
			a = step(a, 3);
			apb(0, `RDT_OFF_VALUE, 0); `CHK(rd, a)
		end
		`CHK(irq, 1'b1)
		apb(1, `RDT_OFF_CTRL, 0);
		apb(1, `RDT_OFF_STATUS, 0);
		idle(2); `CHK(irq, 1'b1)
		apb(1, `RDT_OFF_MASK, 0);
		idle(2); `CHK(irq, 1'b0)
		apb(1, `RDT_OFF_MASK, 1);
		idle(2); `CHK(irq, 1'b1)
		apb(0, `RDT_OFF_STATUS, 0); `CHK(rd, 32'h1)
		apb(0, `RDT_OFF_STATUS, 0); `CHK(rd, 32'h0)
		// Reload zero sets pending every cycle, so neither a write nor a read clear wins
		mReload = 32'h0;
		apb(1, `RDT_OFF_RELOAD, mReload);
		apb(1, `RDT_OFF_VALUE, 0);
		apb(1, `RDT_OFF_CTRL, 32'h9);
		apb(1, `RDT_OFF_STATUS, 1);
		`CHK(irq, 1'b1)
		apb(0, `RDT_OFF_STATUS, 0); `CHK(rd, 32'h1)
		`CHK(irq, 1'b1)
		apb(1, `RDT_OFF_CTRL, 0);
		apb(1, `RDT_OFF_STATUS, 1);
		idle(2); `CHK(irq, 1'b0)
		// Zero reached with interrupt enable off leaves status clear
		apb(1, `RDT_OFF_VALUE, 2);
		apb(1, `RDT_OFF_CTRL, 1);
		idle(8);
		apb(1, `RDT_OFF_CTRL, 0);
		apb(0, `RDT_OFF_STATUS, 0); `CHK(rd, 32'h0)
		// Reset with run off brings control, reload and mask back to their reset values
		apb(1, `RDT_OFF_RELOAD, 32'h5);
		apb(1, `RDT_OFF_MASK, 0);
		apb(1, `RDT_OFF_CTRL, 32'h8);
		rstn <= 1'b0;
		idle(2);
		rstn <= 1'b1;
		idle(3);
		apb(0, `RDT_OFF_CTRL, 0); `CHK(rd, 32'h0)
		apb(0, `RDT_OFF_RELOAD, 0); `CHK(rd, 32'h0)
		apb(0, `RDT_OFF_MASK, 0); `CHK(rd, 32'h1)
		// External start edge
		apb(1, `RDT_OFF_VALUE, 32'h100);
		apb(1, `RDT_OFF_CTRL, 3);
		idle(6);
		apb(0, `RDT_OFF_VALUE, 0); `CHK(rd, 32'h100)
		pins(1, 4);
		apb(0, `RDT_OFF_VALUE, 0);
		a = step(rd, 3);
		apb(0, `RDT_OFF_VALUE, 0); `CHK(rd, a)
		// External slow clock: one tick per pin rising edge
		apb(1, `RDT_OFF_CTRL, 0);
		apb(1, `RDT_OFF_VALUE, 32'h40);
		apb(1, `RDT_OFF_CTRL, 5);
		b = (rnd() & 32'h7) + 32'h3;
		pins(b[7:0], 4'h2 + 4'(b[0]));
		apb(0, `RDT_OFF_VALUE, 0); `CHK(rd, 32'h40 - b)
		test_done;
	end
endmodule
